// ### src/fbm_map.vh
// Register map, field positions and timing figures of the fieldbus master.
`ifndef FBM_MAP_VH
`define FBM_MAP_VH
// Byte offsets of the Avalon-MM registers; the image windows are given by address bits 5:4.
`define FBM_REG_CTRL     6'h00
`define FBM_REG_STATUS   6'h04
`define FBM_REG_MASK     6'h08
`define FBM_REG_LINKSTAT 6'h0C
`define FBM_OUT_BASE     2'h1
`define FBM_IN_BASE      2'h2
// Control register fields.
`define FBM_CTRL_MODE_LO 0
`define FBM_CTRL_MODE_HI 1
`define FBM_CTRL_T32     2
`define FBM_CTRL_LONG    3
`define FBM_CTRL_FATAL   4
`define FBM_CTRL_NONFAT  5
`define FBM_CTRL_RESET   6'h04
// Controller modes.
`define FBM_MODE_PROG    2'h0
`define FBM_MODE_RUN     2'h1
`define FBM_MODE_MON     2'h2
// Status and mask bit positions.
`define FBM_ST_LINKERR   0
`define FBM_ST_FRAME     1
`define FBM_ST_UPDATE    2
`define FBM_ST_BOOT      3
// Clock rate and half-bit rates in units of 500 kHz (high speed) or 500 kHz / 8 (long distance), fractional divider.
`define FBM_CLK_MHZ      20
`define FBM_HALF_STEP    9'h003
`define FBM_HALF_MOD_HS  9'h028
`define FBM_HALF_MOD_LD  9'h140
// Refresh cycle times in microseconds.
`define FBM_CYC_HS32_US  800
`define FBM_CYC_HS16_US  500
`define FBM_CYC_LD32_US  6000
`define FBM_CYC_LD16_US  4000
// Image sizes per direction.
`define FBM_BITS_32      8'h80
`define FBM_BITS_16      8'h40
// Error indicator blink half period in milliseconds.
`define FBM_BLINK_MS     250
`endif

// ### src/fbm_cyclic_io.v
// Fieldbus master with cyclic image exchange.
// Function
// - Link carries only cyclic image refresh.
// - Supports 32 or 16 terminal setting.
// - 32 terminals: 128 in, 128 out.
// - 16 terminals: 64 in, 64 out.
// - High speed cycle 0.8 ms or 0.5 ms.
// - Long distance cycle 6.0 ms or 4.0 ms.
// - Check symbols, length, parity, two-transfer match.
// - Run lamp lit in run or monitor.
// - Run lamp dark in program or fatal.
// - Error lamp steady after fatal error.
// - Error lamp blinks on non-fatal, else dark.
// - Transmit lamp lit while sending.
// - Receive lamp lit while receiving.
// - Link error lamp lit on link error.
// - Serial lamp blinks on port activity.
// - Copy program and read-only data from flash.
//
// Added by the designer: the Avalon-MM slave port and the register addresses.
`timescale 1ns/100ps
`include "fbm_map.vh"
module fbm_cyclic_io #(
    parameter CYC_HS32   = `FBM_CYC_HS32_US * `FBM_CLK_MHZ,   // Cycle counts in clock periods.
    parameter CYC_HS16   = `FBM_CYC_HS16_US * `FBM_CLK_MHZ,
    parameter CYC_LD32   = `FBM_CYC_LD32_US * `FBM_CLK_MHZ,
    parameter CYC_LD16   = `FBM_CYC_LD16_US * `FBM_CLK_MHZ,
    parameter BLINK_CYC  = `FBM_BLINK_MS * 1000 * `FBM_CLK_MHZ, // Blink half period.
    parameter BOOT_WORDS = 4608,                                 // Words copied from flash.
    parameter BOOT_AW    = 13                                    // Boot address width.
) (
    // Clock and reset.
    input  wire                sys_clk,
    input  wire                rstn,
    // Avalon-MM slave.
    input  wire [5:0]          avs_address,
    input  wire                avs_read,
    input  wire                avs_write,
    input  wire [31:0]         avs_writedata,
    output reg  [31:0]         avs_readdata,
    output wire                avs_waitrequest,
    output wire                irq,
    // Fieldbus line, half duplex.
    input  wire                line_i,
    output reg                 line_o,
    output reg                 line_oe,
    // Serial port activity inputs.
    input  wire                periph_active,
    input  wire                aux_active,
    // Flash read port.
    output reg  [BOOT_AW-1:0]  flash_addr,
    output reg                 flash_rd,
    input  wire [15:0]         flash_rdata,
    input  wire                flash_valid,
    // Working program area write port.
    output reg  [BOOT_AW-1:0]  prog_addr,
    output reg  [15:0]         prog_wdata,
    output reg                 prog_we,
    // Indicators.
    output wire                power_indicator,
    output wire                run_indicator,
    output wire                err_indicator,
    output wire                tx_activity_indicator,
    output wire                rx_activity_indicator,
    output wire                link_error_indicator,
    output wire                serial_activity_indicator
);

    // Frame sequencer states, one-hot.
    localparam [3:0] ST_BOOT = 4'h1;
    localparam [3:0] ST_IDLE = 4'h2;
    localparam [3:0] ST_TX   = 4'h4;
    localparam [3:0] ST_RX   = 4'h8;

    reg         rst_q1;        // First reset synchroniser stage.
    reg         rst_n_s;       // Synchronised reset used everywhere else.
    reg  [5:0]  ctrl;          // Mode, terminal setting, speed, error flags.
    reg  [3:0]  status;        // Sticky event bits.
    reg  [3:0]  mask;          // Interrupt mask.
    reg  [3:0]  state;         // Sequencer state.
    reg  [127:0] out_img;      // Output image sent to terminals.
    reg  [127:0] in_img;       // Accepted input image.
    reg  [127:0] rx_img;       // Image being received.
    reg  [127:0] prev_img;     // Previous reception for comparison.
    reg  [7:0]  idx;           // Bit index within the frame.
    reg         half;          // Second half of a Manchester symbol.
    reg         first;         // Sample of the first half.
    reg         par;           // Running parity.
    reg         err_sym;       // Symbol violation seen this frame.
    reg  [8:0]  acc;           // Fractional half-bit divider.
    reg  [23:0] cyc_cnt;       // Refresh cycle timer.
    reg  [23:0] blink_cnt;     // Blink divider.
    reg         blink;         // Blink phase.
    reg         ack;           // Bus answer cycle.
    reg  [3:0]  link_stat;     // Last failure causes in bits 0 to 2: sym, len, parity.
    reg  [3:0]  ev;            // Events raised this cycle.
    reg         boot_wait;     // Flash read outstanding.

    wire        t32     = ctrl[`FBM_CTRL_T32];
    wire        ld      = ctrl[`FBM_CTRL_LONG];
    wire        fatal   = ctrl[`FBM_CTRL_FATAL];
    wire [1:0]  mode    = ctrl[`FBM_CTRL_MODE_HI:`FBM_CTRL_MODE_LO];
    wire [7:0]  nbits   = t32 ? `FBM_BITS_32 : `FBM_BITS_16;
    wire [8:0]  hmod    = ld ? `FBM_HALF_MOD_LD : `FBM_HALF_MOD_HS;
    wire [8:0]  acc_nx  = acc + `FBM_HALF_STEP;
    wire        half_en = (acc_nx >= hmod);
    wire [23:0] cyc_len = ld ? (t32 ? CYC_LD32[23:0] : CYC_LD16[23:0])
                             : (t32 ? CYC_HS32[23:0] : CYC_HS16[23:0]);
    wire        cyc_end = (cyc_cnt >= cyc_len - 24'h000001);  // A shorter new setting cannot be overrun.
    wire        cyc_late = (cyc_cnt >= cyc_len - 24'h000002); // Last two cycles of a frame, so idle still sees the end.
    wire [127:0] use_msk = t32 ? {128{1'b1}} : {64'h0, {64{1'b1}}};
    wire        tx_bit  = (idx == nbits) ? par : out_img[idx[6:0]];
    wire        req     = avs_read | avs_write;
    wire        wr_acc  = avs_write & ack;
    wire [3:0]  w1c     = (wr_acc && avs_address == `FBM_REG_STATUS) ? avs_writedata[3:0] : 4'h0;

    // Bus handshake: one wait cycle, answer on the second.
    assign avs_waitrequest = req & ~ack;
    assign irq             = |(status & mask);

    // Indicators.
    assign power_indicator           = 1'b1;
    assign run_indicator             = ~fatal & (mode == `FBM_MODE_RUN || mode == `FBM_MODE_MON);
    assign err_indicator             = fatal | (ctrl[`FBM_CTRL_NONFAT] & blink);
    assign tx_activity_indicator     = state[2];
    assign rx_activity_indicator     = state[3];
    assign link_error_indicator      = status[`FBM_ST_LINKERR];
    assign serial_activity_indicator = (periph_active | aux_active) & blink;

    // Reset release through two flip-flops.
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_q1  <= 1'b0;
            rst_n_s <= 1'b0;
        end else begin
            rst_q1  <= 1'b1;
            rst_n_s <= rst_q1;
        end
    end

    // Blink divider shared by the error and serial lamps.
    always @(posedge sys_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            blink_cnt <= 24'h000000;
            blink     <= 1'b0;
        end else if (blink_cnt == BLINK_CYC[23:0] - 24'h000001) begin
            blink_cnt <= 24'h000000;
            blink     <= ~blink;
        end else begin
            blink_cnt <= blink_cnt + 24'h000001;
        end
    end

    // Register writes and the bus answer flag.
    always @(posedge sys_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            ctrl    <= `FBM_CTRL_RESET;
            mask    <= 4'h0;
            out_img <= 128'h0;
            ack     <= 1'b0;
        end else begin
            ack <= req & ~ack;
            if (wr_acc) begin
                if (avs_address == `FBM_REG_CTRL) begin
                    ctrl <= avs_writedata[5:0];
                end else if (avs_address == `FBM_REG_MASK) begin
                    mask <= avs_writedata[3:0];
                end else if (avs_address[5:4] == `FBM_OUT_BASE) begin
                    out_img[{avs_address[3:2], 5'h00} +: 32] <= avs_writedata;
                end
            end
        end
    end

    // Read data mux; unmapped addresses read zero.
    always @(posedge sys_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            avs_readdata <= 32'h0;
        end else if (avs_read & ~ack) begin
            if (avs_address == `FBM_REG_CTRL) begin
                avs_readdata <= {26'h0, ctrl};
            end else if (avs_address == `FBM_REG_STATUS) begin
                avs_readdata <= {28'h0, status};
            end else if (avs_address == `FBM_REG_MASK) begin
                avs_readdata <= {28'h0, mask};
            end else if (avs_address == `FBM_REG_LINKSTAT) begin
                avs_readdata <= {28'h0, link_stat};
            end else if (avs_address[5:4] == `FBM_OUT_BASE) begin
                avs_readdata <= out_img[{avs_address[3:2], 5'h00} +: 32];
            end else if (avs_address[5:4] == `FBM_IN_BASE) begin
                avs_readdata <= in_img[{avs_address[3:2], 5'h00} +: 32];
            end else begin
                avs_readdata <= 32'h0;
            end
        end
    end

    // Sticky status: a set in the same cycle as its clear wins.
    always @(posedge sys_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            status <= 4'h0;
        end else begin
            status <= (status & ~w1c) | ev;
        end
    end

    // Half-bit enable from a fractional divider, restarted at each frame.
    always @(posedge sys_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            acc <= 9'h000;
        end else if (state[1] | state[0]) begin
            acc <= 9'h000;
        end else if (half_en) begin
            acc <= acc_nx - hmod;
        end else begin
            acc <= acc_nx;
        end
    end

    // Refresh cycle timer paces frame starts.
    always @(posedge sys_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            cyc_cnt <= 24'h000000;
        end else if (state[0] | cyc_end) begin
            cyc_cnt <= 24'h000000;
        end else begin
            cyc_cnt <= cyc_cnt + 24'h000001;
        end
    end

    // Boot copy from flash to the working program area.
    always @(posedge sys_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            flash_addr <= {BOOT_AW{1'b0}};
            flash_rd   <= 1'b0;
            boot_wait  <= 1'b0;
            prog_addr  <= {BOOT_AW{1'b0}};
            prog_wdata <= 16'h0000;
            prog_we    <= 1'b0;
        end else begin
            flash_rd <= 1'b0;
            prog_we  <= 1'b0;
            if (state[0] && !boot_wait && !prog_we) begin
                flash_rd  <= 1'b1;
                boot_wait <= 1'b1;
            end else if (boot_wait && flash_valid) begin
                boot_wait  <= 1'b0;
                prog_addr  <= flash_addr;
                prog_wdata <= flash_rdata;
                prog_we    <= 1'b1;
                flash_addr <= flash_addr + 1'b1;
            end
        end
    end

    // Frame sequencer: send image and parity, then receive them.
    always @(posedge sys_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            state     <= ST_BOOT;
            idx       <= 8'h00;
            half      <= 1'b0;
            first     <= 1'b0;
            par       <= 1'b0;
            err_sym   <= 1'b0;
            line_o    <= 1'b0;
            line_oe   <= 1'b0;
            rx_img    <= 128'h0;
            prev_img  <= 128'h0;
            in_img    <= 128'h0;
            link_stat <= 4'h0;
            ev        <= 4'h0;
        end else begin
            ev <= 4'h0;
            case (state)
                ST_BOOT: begin
                    // Frames wait until the whole image has been copied.
                    if (prog_we && prog_addr == BOOT_WORDS[BOOT_AW-1:0] - 1'b1) begin
                        state <= ST_IDLE;
                        ev    <= 4'h1 << `FBM_ST_BOOT;
                    end
                end
                ST_IDLE: begin
                    // Only cyclic refresh frames exist; a frame starts on each cycle boundary unless the fatal flag is set.
                    if (cyc_end && !fatal) begin
                        state   <= ST_TX;
                        idx     <= 8'h00;
                        half    <= 1'b0;
                        par     <= 1'b0;
                        err_sym <= 1'b0;
                        line_oe <= 1'b1;
                    end
                end
                ST_TX: begin
                    if (half_en) begin
                        half <= ~half;
                        if (!half) begin
                            line_o <= tx_bit;
                        end else begin
                            line_o <= ~tx_bit;
                            par    <= par ^ tx_bit;
                            if (idx == nbits) begin
                                state   <= ST_RX;
                                idx     <= 8'h00;
                                par     <= 1'b0;
                                line_oe <= 1'b0;
                                line_o  <= 1'b0;
                            end else begin
                                idx <= idx + 8'h01;
                            end
                        end
                    end
                end
                ST_RX: begin
                    if (cyc_late) begin
                        // Frame ran out of time: too short. Idle then starts the next frame on time.
                        state     <= ST_IDLE;
                        link_stat <= 4'h2;
                        ev        <= 4'h1 << `FBM_ST_LINKERR;
                    end else if (half_en) begin
                        half <= ~half;
                        if (!half) begin
                            first <= line_i;
                        end else begin
                            if (first == line_i) begin
                                err_sym <= 1'b1;
                            end
                            par <= par ^ first;
                            if (idx == nbits) begin
                                state <= ST_IDLE;
                                if (err_sym || first == line_i || (par ^ first)) begin
                                    link_stat <= {1'b0, par ^ first, 1'b0, err_sym | (first == line_i)};
                                    ev        <= 4'h1 << `FBM_ST_LINKERR;
                                end else begin
                                    prev_img <= rx_img;
                                    if (((rx_img ^ prev_img) & use_msk) == 128'h0) begin
                                        in_img <= rx_img & use_msk;
                                        ev     <= (4'h1 << `FBM_ST_FRAME) | (4'h1 << `FBM_ST_UPDATE);
                                    end else begin
                                        ev <= 4'h1 << `FBM_ST_FRAME;
                                    end
                                end
                            end else begin
                                rx_img[idx[6:0]] <= first;
                                idx              <= idx + 8'h01;
                            end
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // fbm_cyclic_io

// ### sim/fbm_monitor.sv
// Port-level checker of the fieldbus master, bound to its top module.
`timescale 1ns/100ps
`include "fbm_map.vh"
module fbm_monitor (
    // Clock, reset and register bus.
    input wire        sys_clk,
    input wire        rstn,
    input wire [5:0]  avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire        avs_waitrequest,
    // Line, serial ports and boot copy.
    input wire        line_oe,
    input wire        periph_active,
    input wire        aux_active,
    input wire        flash_valid,
    input wire [15:0] flash_rdata,
    input wire        prog_we,
    input wire [15:0] prog_wdata,
    // Indicators.
    input wire        run_indicator,
    input wire        err_indicator,
    input wire        tx_activity_indicator,
    input wire        rx_activity_indicator,
    input wire        link_error_indicator,
    input wire        serial_activity_indicator
);
    wire      wr_ok = avs_write && !avs_waitrequest; // A write takes effect in this cycle.
    reg [5:0] ctrl;                                  // Shadow of the control register.
    // Follow every accepted control write, so lamp checks know the mode.
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) ctrl <= `FBM_CTRL_RESET;
        else if (wr_ok && avs_address == `FBM_REG_CTRL) ctrl <= avs_writedata[5:0];
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // A request waits exactly one cycle.
    sequence s_one_wait;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    // A flash word lands in the program area unchanged.
    sequence s_copied;
        prog_we && prog_wdata == $past(flash_rdata);
    endsequence
    a_bus_one_wait: assert property ($rose(avs_read || avs_write) |-> s_one_wait)
        else $error("bus wait not one cycle");
    a_tx_lamp_drive: assert property (tx_activity_indicator == line_oe)
        else $error("tx lamp not line drive");
    a_rx_lamp_quiet: assert property (rx_activity_indicator |-> !line_oe)
        else $error("rx lamp lit in tx");
    a_rx_after_tx: assert property ($fell(line_oe) |-> ##[0:1] rx_activity_indicator)
        else $error("rx lamp dark after tx");
    a_run_lamp_mode: assert property (run_indicator == (!ctrl[`FBM_CTRL_FATAL] &&
        (ctrl[1:0] == `FBM_MODE_RUN || ctrl[1:0] == `FBM_MODE_MON))) else $error("run lamp wrong");
    a_err_lamp_fatal: assert property (ctrl[`FBM_CTRL_FATAL] |-> err_indicator)
        else $error("err lamp dark on fatal");
    a_err_lamp_dark: assert property (!ctrl[`FBM_CTRL_FATAL] && !ctrl[`FBM_CTRL_NONFAT] |-> !err_indicator)
        else $error("err lamp lit in normal");
    a_link_lamp_held: assert property (link_error_indicator && !(wr_ok && avs_address == `FBM_REG_STATUS
        && avs_writedata[0]) |=> link_error_indicator) else $error("link error lost");
    a_serial_lamp_dark: assert property (!periph_active && !aux_active |-> !serial_activity_indicator)
        else $error("serial lamp lit idle");
    a_boot_copy_step: assert property (flash_valid |=> s_copied)
        else $error("flash word not copied");
endmodule // fbm_monitor
bind fbm_cyclic_io fbm_monitor u_monitor (.*);

// ### sim/fbm_terminals.sv
// Behavioural model of the remote input and output terminals on the line.
`timescale 1ns/100ps
module fbm_terminals (
    // Clock and line.
    input  wire         sys_clk,
    input  wire         line_o,
    input  wire         line_oe,
    output reg          line_i,
    // Controls and what was heard.
    input  wire [7:0]   nbits,
    input  wire [127:0] reply,
    input  wire         bad_parity,
    output reg  [127:0] heard
);
    reg     [39:0]  phase;   // Residues from frame start where the master steps a half bit.
    reg     [128:0] word;    // Reply bits with the parity bit on top.
    reg             last_o;  // Line level one cycle ago.
    reg             was_oe;  // Master drive one cycle ago.
    reg             talking; // Reply in progress.
    integer         tick;    // Cycles since the master began to drive.
    integer         half;    // Index of the half bit now on the line.
    wire            step = phase[tick % 40];
    initial begin
        {phase, last_o, was_oe, talking, line_i, heard, tick, half} = 0;
    end
    // Learn the half-bit grid from the master's edges, decode it, answer on it.
    always @(posedge sys_clk) begin
        tick <= (line_oe && !was_oe) ? 1 : tick + 1;
        last_o <= line_o;
        was_oe <= line_oe;
        if (line_oe && !was_oe) begin
            half <= 0;
        end else if (line_oe) begin
            if (line_o != last_o) phase[tick % 40] <= 1'b1;
            if (step) begin
                if (half % 2 == 0 && half / 2 < nbits) heard[half / 2] <= line_o;
                half <= half + 1;
            end
        end else if (was_oe) begin
            word = {1'b0, reply};
            word[nbits] = ^reply ^ bad_parity;
            line_i <= word[0];
            half <= 1;
            talking <= 1'b1;
        end else if (talking && step) begin
            if (half < 2 * nbits + 2) line_i <= word[half / 2] ^ half[0];
            else talking <= 1'b0;
            half <= half + 1;
        end else if (!talking) begin
            line_i <= ~line_i; // A released line shows no stale level.
        end
    end
endmodule // fbm_terminals

// ### sim/fbm_cyclic_io_test.sv
// Testbench of the fieldbus master with terminal model and boot flash.
`timescale 1ns/100ps
`include "fbm_map.vh"
module fbm_cyclic_io_test;
    reg          sys_clk, rstn, avs_read, avs_write, periph_active, aux_active, flash_valid, bad_parity;
    reg  [5:0]   avs_address;
    reg  [31:0]  avs_writedata;
    reg  [15:0]  flash_rdata, err_h, ser_h;
    reg  [7:0]   nbits;
    reg  [127:0] reply, out_img;
    reg  [63:0]  rdq[$];   // Expected read data with mask in the upper half.
    reg  [28:0]  pwq[$];   // Expected program area writes.
    reg  [63:0]  e;
    reg  [28:0]  p, f;
    wire [31:0]  avs_readdata;
    wire [15:0]  prog_wdata;
    wire [12:0]  flash_addr, prog_addr;
    wire [127:0] heard;
    wire         avs_waitrequest, irq, line_i, line_o, line_oe, flash_rd, prog_we, power_indicator, run_indicator;
    wire         err_indicator, tx_activity_indicator, rx_activity_indicator, link_error_indicator, serial_activity_indicator;
    integer      num_errors, checked, cycles, i, t0;
    localparam   HS32 = 7500, HS16 = 3700, LD16 = 14500;
    fbm_cyclic_io #(.CYC_HS32(HS32), .CYC_HS16(HS16), .CYC_LD32(30000), .CYC_LD16(LD16), .BLINK_CYC(8),
        .BOOT_WORDS(4)) dut (.*);
    fbm_terminals far_end (.*);
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // Flash model, lamp history and timeout.
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        err_h <= {err_h[14:0], err_indicator};
        ser_h <= {ser_h[14:0], serial_activity_indicator};
        flash_valid <= flash_rd;
        if (flash_rd) begin
            f = {flash_addr, 16'h0} | ($urandom & 32'hFFFF);
            flash_rdata <= f[15:0];
            pwq.push_back(f);
        end
        if (cycles == 100000) begin
            num_errors = num_errors + 1;
            final_report;
        end
    end
    // Watcher: compares settled answers with the oldest note.
    always @(negedge sys_clk) begin
        if (avs_read && !avs_waitrequest && rdq.size() > 0) begin
            e = rdq.pop_front();
            cmp_word(avs_readdata & e[63:32], e[31:0]);
        end
        if (prog_we && pwq.size() > 0) begin
            p = pwq.pop_front();
            cmp_word({3'h0, prog_addr, prog_wdata}, {3'h0, p});
        end
    end
    task cmp_word(input [31:0] got, input [31:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("[FAIL] %0t: got %h, expected %h", $time, got, exp);
            end
        end
    endtask
    // One Avalon transfer; for a read, d is the expected value under mask m.
    task bus(input w, input [5:0] a, input [31:0] d, input [31:0] m);
        begin
            @(posedge sys_clk);
            avs_address <= a;
            avs_write <= w;
            avs_read <= !w;
            avs_writedata <= d;
            if (!w) rdq.push_back({m, d & m});
            @(negedge sys_clk);
            while (avs_waitrequest !== 1'b0) @(negedge sys_clk);
            @(posedge sys_clk);
            avs_write <= 1'b0;
            avs_read <= 1'b0;
        end
    endtask
    task frames(input integer n);
        begin
            repeat (n) @(negedge rx_activity_indicator);
            @(posedge sys_clk);
        end
    endtask
    task period(input integer n);
        begin
            @(posedge line_oe);
            t0 = $time;
            @(posedge line_oe);
            cmp_word(($time - t0) / 50, n);
        end
    endtask
    task final_report;
        begin
            if (num_errors == 0 && checked > 0) $display("Finished cleanly");
            else $display("Finished with errors");
            $finish;
        end
    endtask
    initial begin
        i = $urandom(32'h2BC5D19D);
        {rstn, avs_read, avs_write, periph_active, aux_active, flash_valid, bad_parity} = 0;
        {avs_address, avs_writedata, flash_rdata, err_h, ser_h} = 0;
        {num_errors, checked, cycles} = 0;
        nbits = 8'h80;
        reply = {$urandom, $urandom, $urandom, $urandom};
        out_img = {$urandom, $urandom, $urandom, $urandom};
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge sys_clk);
        bus(0, `FBM_REG_CTRL, `FBM_CTRL_RESET, 32'h3F);
        for (i = 0; i < 4; i = i + 1) bus(1, {`FBM_OUT_BASE, i[1:0], 2'h0}, out_img[32 * i +: 32], 0);
        bus(1, `FBM_REG_MASK, 32'h2, 0);
        bus(0, 6'h3C, 0, 32'hFFFFFFFF);
        repeat (20) @(posedge sys_clk);
        bus(0, `FBM_REG_STATUS, 32'h8, 32'h8);
        for (i = 0; i < 6; i = i + 1) begin
            bus(1, `FBM_REG_CTRL, (i / 3) * 16 + 4 + i % 3, 0);
            @(posedge sys_clk);
            cmp_word(run_indicator, i < 3 && i % 3 != 0);
            cmp_word(err_indicator, i / 3);
        end
        bus(1, `FBM_REG_CTRL, 32'h25, 0);
        for (i = 0; i < 24; i = i + 1) begin
            @(posedge sys_clk);
            periph_active <= $urandom;
            aux_active <= $urandom;
        end
        @(posedge sys_clk);
        periph_active <= 1'b1;
        aux_active <= 1'b0;
        repeat (20) @(posedge sys_clk);
        cmp_word(err_h != 0 && err_h != 16'hFFFF, 1);
        cmp_word(ser_h != 0 && ser_h != 16'hFFFF, 1);
        bus(1, `FBM_REG_CTRL, 32'h05, 0);
        @(posedge sys_clk);
        cmp_word(err_indicator, 0);
        cmp_word(power_indicator, 1);
        period(HS32);
        bus(1, `FBM_REG_STATUS, 32'hF, 0);
        frames(2);
        for (i = 0; i < 4; i = i + 1) begin
            bus(0, {`FBM_IN_BASE, i[1:0], 2'h0}, reply[32 * i +: 32], 32'hFFFFFFFF);
            cmp_word(heard[32 * i +: 32], out_img[32 * i +: 32]);
        end
        bus(0, `FBM_REG_STATUS, 32'h2, 32'h3);
        cmp_word(irq, 1);
        bus(1, `FBM_REG_STATUS, 32'hF, 0);
        bus(0, `FBM_REG_STATUS, 32'h0, 32'h3);
        cmp_word(irq, 0);
        nbits <= 8'h40;
        reply <= {64'h0, $urandom, $urandom};
        bus(1, `FBM_REG_CTRL, 32'h01, 0);
        period(HS16);
        frames(2);
        for (i = 0; i < 2; i = i + 1) begin
            bus(0, {`FBM_IN_BASE, i[1:0], 2'h0}, reply[32 * i +: 32], 32'hFFFFFFFF);
            cmp_word(heard[32 * i +: 32], out_img[32 * i +: 32]);
        end
        bad_parity <= 1'b1;
        reply <= {64'h0, ~reply[63:0]};
        bus(1, `FBM_REG_MASK, 32'h1, 0);
        frames(2);
        cmp_word(link_error_indicator, 1);
        cmp_word(irq, 1);
        bus(0, `FBM_REG_LINKSTAT, 32'h4, 32'h4);
        bus(0, {`FBM_IN_BASE, 4'h0}, ~reply[31:0], 32'hFFFFFFFF);
        bad_parity <= 1'b0;
        bus(1, `FBM_REG_STATUS, 32'h1, 0);
        @(posedge sys_clk);
        cmp_word(link_error_indicator, 0);
        bus(1, `FBM_REG_CTRL, 32'h09, 0);
        period(LD16);
        repeat (3) @(posedge sys_clk);
        bus(0, `FBM_REG_LINKSTAT, 32'h2, 32'h2);
        final_report;
    end
endmodule // fbm_cyclic_io_test
